// ---- rtl/fepe_pkg.sv ----
package fepe_pkg;
  // Clock.
  localparam longint unsigned CLK_HZ        = 64'd50_000_000;
  localparam int unsigned     CLK_PERIOD_NS = 20;
  localparam int unsigned     SYNC_STAGES   = 2;
  // Pin timing in ns and the cycle counts derived from it (least times round up).
  localparam int unsigned     WE_LOW_NS     = 45;
  localparam int unsigned     WE_HIGH_NS    = 20;
  localparam int unsigned     RD_ACC_NS     = 90;
  localparam int unsigned     RD_FLOAT_NS   = 40;
  localparam logic [3:0] WE_LOW_CYC  = 4'((WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WE_HIGH_CYC = 4'((WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RD_CYC      =
    4'((RD_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
  localparam logic [3:0] RD_GAP_CYC  = 4'((RD_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Longest internal durations the host must tolerate.
  localparam longint unsigned BYTE_PROGRAM_DURATION_US = 64'd300;
  localparam longint unsigned SECTOR_ERASE_DURATION_S  = 64'd30;
  localparam longint unsigned CHIP_ERASE_DURATION_S    = 64'd256;
  localparam int unsigned     WAIT_W = 34;
  localparam longint unsigned PROG_WAIT_CYC_DEF  = BYTE_PROGRAM_DURATION_US * CLK_HZ / 64'd1_000_000;
  localparam longint unsigned SECT_WAIT_CYC_DEF  = SECTOR_ERASE_DURATION_S * CLK_HZ;
  localparam longint unsigned CHIP_WAIT_CYC_DEF  = CHIP_ERASE_DURATION_S * CLK_HZ;
  // Register offsets.
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] ADDR_OFS   = 12'h004;
  localparam logic [11:0] WDATA_OFS  = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00C;
  localparam logic [11:0] RDATA_OFS  = 12'h010;
  // Operation codes written to the control register.
  localparam logic [2:0] OP_NONE  = 3'h0;
  localparam logic [2:0] OP_READ  = 3'h1;
  localparam logic [2:0] OP_PROG  = 3'h2;
  localparam logic [2:0] OP_CHIP  = 3'h3;
  localparam logic [2:0] OP_SECT  = 3'h4;
  localparam logic [2:0] OP_RESET = 3'h5;
  // Command bus cycles.
  localparam logic [20:0] UNLOCK1_ADDR = 21'h000555;
  localparam logic [20:0] UNLOCK2_ADDR = 21'h0002AA;
  localparam logic [7:0]  UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
  localparam logic [7:0]  CMD_PROG     = 8'hA0;
  localparam logic [7:0]  CMD_ERASE    = 8'h80;
  localparam logic [7:0]  CMD_CHIP     = 8'h10;
  localparam logic [7:0]  CMD_SECT     = 8'h30;
  localparam logic [7:0]  CMD_RESET    = 8'hF0;
  localparam int unsigned SECT_LSB     = 16;
  // Status bit positions on the data lines.
  localparam int unsigned POLL_BIT   = 7;
  localparam int unsigned TOGGLE_BIT = 6;
  localparam int unsigned TMO_BIT    = 5;
  localparam int unsigned EWIN_BIT   = 3;
  // Status register fields.
  localparam int unsigned STS_BUSY   = 0;
  localparam int unsigned STS_DONE   = 1;
  localparam int unsigned STS_FAIL   = 2;
  localparam int unsigned STS_HTMO   = 3;
  localparam int unsigned STS_TMO    = 4;
  localparam int unsigned STS_EWIN   = 5;
  localparam int unsigned STS_DATA   = 8;

  typedef enum logic [2:0] {ST_IDLE, ST_WSETUP, ST_WPULSE, ST_WGAP, ST_RPULSE, ST_RGAP}
    fepe_state_t;
endpackage : fepe_pkg

// ---- rtl/fepe_host.sv ----
`timescale 1ns/100ps
module fepe_host #(
  parameter longint unsigned PROG_WAIT_CYC = fepe_pkg::PROG_WAIT_CYC_DEF,
  parameter longint unsigned SECT_WAIT_CYC = fepe_pkg::SECT_WAIT_CYC_DEF,
  parameter longint unsigned CHIP_WAIT_CYC = fepe_pkg::CHIP_WAIT_CYC_DEF
) (
  // Clock, reset and enable.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Flash pins.
  output logic      [20:0] flash_addr,
  output logic      [7:0]  flash_dq_o,
  output logic             flash_dq_oe,
  input  wire logic [7:0]  flash_dq_i,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n
);
  import fepe_pkg::*;

  fepe_state_t       state_q;
  fepe_state_t       after_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic [20:0]       addr_q;
  logic [7:0]        wdata_q;
  logic [2:0]        op_q;
  logic [2:0]        step_q;
  logic [3:0]        cnt_q;
  logic [WAIT_W-1:0] wait_q;
  logic              polling_q;
  logic              first_q;
  logic              recheck_q;
  logic [7:0]        prev_q;
  logic [7:0]        rdata_q;
  logic              done_q;
  logic              fail_q;
  logic              htmo_q;
  logic [7:0]        dq_s1_q;
  logic [7:0]        dq_s2_q;
  logic [20:0]       fa_q;
  logic [7:0]        fd_q;
  logic              foe_q;
  logic              fce_q;
  logic              fre_q;
  logic              fwe_q;

  function automatic logic [28:0] fepe_step(input logic [2:0] op, input logic [2:0] idx,
                                            input logic [20:0] a, input logic [7:0] d);
    logic [28:0] r;
    r = {a, CMD_RESET};
    if (op == OP_PROG) begin
      case (idx)
        3'h0:    r = {UNLOCK1_ADDR, UNLOCK1_DATA};
        3'h1:    r = {UNLOCK2_ADDR, UNLOCK2_DATA};
        3'h2:    r = {UNLOCK1_ADDR, CMD_PROG};
        default: r = {a, d};
      endcase
    end else if (op == OP_CHIP || op == OP_SECT) begin
      case (idx)
        3'h0, 3'h3: r = {UNLOCK1_ADDR, UNLOCK1_DATA};
        3'h1, 3'h4: r = {UNLOCK2_ADDR, UNLOCK2_DATA};
        3'h2:       r = {UNLOCK1_ADDR, CMD_ERASE};
        default: begin
          if (op == OP_CHIP) begin
            r = {UNLOCK1_ADDR, CMD_CHIP};
          end else begin
            r = {a[20:SECT_LSB], 16'h0000, CMD_SECT};
          end
        end
      endcase
    end
    return r;
  endfunction : fepe_step

  function automatic logic [2:0] fepe_nsteps(input logic [2:0] op);
    case (op)
      OP_PROG:          return 3'h4;
      OP_CHIP, OP_SECT: return 3'h6;
      default:          return 3'h1;
    endcase
  endfunction : fepe_nsteps

  logic        acc;
  logic        wr_take;
  logic        start;
  logic        sample;
  logic [7:0]  rd;
  logic [28:0] stp;
  logic        mapped;
  logic        toggled;

  assign acc     = psel & penable;
  assign wr_take = acc & pready_q & pwrite;
  assign start   = wr_take && paddr == CTRL_OFS && state_q == ST_IDLE &&
                   pwdata[2:0] != OP_NONE && pwdata[2:0] <= OP_RESET;
  assign sample  = state_q == ST_RPULSE && cnt_q == 4'h0;
  assign rd      = dq_s2_q;
  assign toggled = prev_q[TOGGLE_BIT] != rd[TOGGLE_BIT];
  assign stp     = fepe_step(op_q, step_q, addr_q, wdata_q);
  assign mapped  = paddr == CTRL_OFS || paddr == ADDR_OFS || paddr == WDATA_OFS ||
                   paddr == STATUS_OFS || paddr == RDATA_OFS;

  // Answer one cycle after the access phase starts; unmapped offsets raise pslverr.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else if (clk_en) begin
      pready_q  <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & ~mapped;
      if (acc && !pready_q) begin
        case (paddr)
          CTRL_OFS:   prdata_q <= {29'h0, op_q};
          ADDR_OFS:   prdata_q <= {11'h000, addr_q};
          WDATA_OFS:  prdata_q <= {24'h000000, wdata_q};
          STATUS_OFS: prdata_q <= {16'h0000, rdata_q, 2'b00, prev_q[EWIN_BIT], prev_q[TMO_BIT],
                                   htmo_q, fail_q, done_q, state_q != ST_IDLE};
          RDATA_OFS:  prdata_q <= {24'h000000, rdata_q};
          default:    prdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // Address and data are latched only while idle so a running sequence stays intact.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q  <= 21'h000000;
      wdata_q <= 8'h00;
    end else if (clk_en && wr_take && state_q == ST_IDLE) begin
      if (paddr == ADDR_OFS) begin
        addr_q <= pwdata[20:0];
      end
      if (paddr == WDATA_OFS) begin
        wdata_q <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
    end else if (clk_en) begin
      dq_s1_q <= flash_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= ST_IDLE;
      after_q   <= ST_IDLE;
      op_q      <= OP_NONE;
      step_q    <= 3'h0;
      cnt_q     <= 4'h0;
      wait_q    <= '0;
      polling_q <= 1'b0;
      first_q   <= 1'b0;
      recheck_q <= 1'b0;
      prev_q    <= 8'h00;
      rdata_q   <= 8'h00;
      done_q    <= 1'b0;
      fail_q    <= 1'b0;
      htmo_q    <= 1'b0;
      fa_q      <= 21'h000000;
      fd_q      <= 8'h00;
      foe_q     <= 1'b0;
      fce_q     <= 1'b1;
      fre_q     <= 1'b1;
      fwe_q     <= 1'b1;
    end else if (clk_en) begin
      if (polling_q && wait_q != '0) begin
        wait_q <= wait_q - 1'b1;
      end
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            op_q   <= pwdata[2:0];
            step_q <= 3'h0;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            htmo_q <= 1'b0;
            fa_q   <= addr_q;
            cnt_q  <= RD_CYC - 4'h1;
            state_q <= pwdata[2:0] == OP_READ ? ST_RPULSE : ST_WSETUP;
            fce_q   <= pwdata[2:0] != OP_READ;
            fre_q   <= pwdata[2:0] != OP_READ;
          end
        end
        ST_WSETUP: begin
          fa_q    <= stp[28:8];
          fd_q    <= stp[7:0];
          foe_q   <= 1'b1;
          fce_q   <= 1'b0;
          fwe_q   <= 1'b0;
          cnt_q   <= WE_LOW_CYC - 4'h1;
          state_q <= ST_WPULSE;
        end
        ST_WPULSE: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            fwe_q   <= 1'b1;
            fce_q   <= 1'b1;
            cnt_q   <= WE_HIGH_CYC - 4'h1;
            state_q <= ST_WGAP;
          end
        end
        ST_WGAP: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (step_q + 3'h1 < fepe_nsteps(op_q)) begin
            step_q  <= step_q + 3'h1;
            state_q <= ST_WSETUP;
          end else begin
            foe_q <= 1'b0;
            fa_q  <= addr_q;
            if (op_q == OP_RESET) begin
              done_q  <= ~fail_q;
              state_q <= ST_IDLE;
            end else begin
              wait_q <= op_q == OP_PROG ? WAIT_W'(PROG_WAIT_CYC) :
                        op_q == OP_SECT ? WAIT_W'(SECT_WAIT_CYC) : WAIT_W'(CHIP_WAIT_CYC);
              polling_q <= 1'b1;
              first_q   <= 1'b0;
              recheck_q <= 1'b0;
              fce_q     <= 1'b0;
              fre_q     <= 1'b0;
              cnt_q     <= RD_CYC - 4'h1;
              state_q   <= ST_RPULSE;
            end
          end
        end
        ST_RPULSE: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            fce_q   <= 1'b1;
            fre_q   <= 1'b1;
            cnt_q   <= RD_GAP_CYC - 4'h1;
            state_q <= ST_RGAP;
            prev_q  <= rd;
            first_q <= 1'b1;
            after_q <= ST_IDLE;
            if (!polling_q) begin
              rdata_q <= rd;
              done_q  <= 1'b1;
            end else if (first_q && !toggled) begin
              rdata_q   <= rd;
              done_q    <= 1'b1;
              polling_q <= 1'b0;
            end else if ((first_q && toggled && recheck_q) || wait_q == '0) begin
              rdata_q   <= rd;
              fail_q    <= 1'b1;
              htmo_q    <= wait_q == '0;
              polling_q <= 1'b0;
              op_q      <= OP_RESET;
              step_q    <= 3'h0;
              after_q   <= ST_WSETUP;
            end else begin
              recheck_q <= first_q & rd[TMO_BIT];
              after_q   <= ST_RPULSE;
            end
          end
        end
        ST_RGAP: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            state_q <= after_q;
            cnt_q   <= RD_CYC - 4'h1;
            fce_q   <= after_q != ST_RPULSE;
            fre_q   <= after_q != ST_RPULSE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign flash_addr  = fa_q;
  assign flash_dq_o  = fd_q;
  assign flash_dq_oe = foe_q;
  assign flash_ce_n  = fce_q;
  assign flash_oe_n  = fre_q;
  assign flash_we_n  = fwe_q;

  default clocking cb @(posedge pclk iff clk_en); endclocking
  default disable iff (!presetn);

  poll_done_a: assert property (sample && polling_q && first_q && !toggled && wait_q != '0
    |=> done_q && !polling_q && state_q == ST_RGAP)
    else $error("equal toggle bits did not end polling");
  chip_wait_a: assert property ($rose(polling_q) && op_q == OP_CHIP
    |-> wait_q == WAIT_W'(CHIP_WAIT_CYC))
    else $error("chip erase wait not loaded");
  sect_wait_a: assert property ($rose(polling_q) && op_q == OP_SECT
    |-> wait_q == WAIT_W'(SECT_WAIT_CYC))
    else $error("sector erase wait not loaded");
  prog_wait_a: assert property ($rose(polling_q) && op_q == OP_PROG
    |-> wait_q == WAIT_W'(PROG_WAIT_CYC))
    else $error("program wait not loaded");
  fail_reset_a: assert property ($rose(fail_q)
    |-> ##[1:12] (!flash_we_n && flash_dq_o == CMD_RESET && flash_dq_oe))
    else $error("failure not followed by reset command");
  we_pulse_a: assert property ($fell(flash_we_n) |-> (!flash_we_n && !flash_ce_n)[*3] ##1 flash_we_n)
    else $error("write pulse width wrong");

  prog_ok_c: cover property ($rose(done_q) && op_q == OP_PROG);
  sect_ok_c: cover property ($rose(done_q) && op_q == OP_SECT);
  fail_c:    cover property ($rose(fail_q));
  read_c:    cover property ($rose(done_q) && op_q == OP_READ);
endmodule : fepe_host

// ---- verif/fepe_flash_model.sv ----
`timescale 1ns/100ps
module fepe_flash_model #(
  parameter int PROG_CYC  = 40,
  parameter int WIN_CYC   = 20,
  parameter int ERASE_CYC = 60,
  parameter int LOCK_CYC  = 30,
  parameter int SLOW_CYC  = 400
) (
  // Paces the timers and samples the strobes; the pins themselves carry no clock.
  input  wire logic        pclk,
  // Flash pins.
  input  wire logic [20:0] flash_addr,
  input  wire logic [7:0]  flash_dq_o,
  input  wire logic        flash_dq_oe,
  output logic      [7:0]  flash_dq_i,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  // Makes the next program outlast the host wait.
  input  wire logic        stretch
);
  import fepe_pkg::*;
  logic [7:0]  mem [0:2097151];
  logic [2:0]  seq, mode;
  logic [4:0]  er_sec;
  logic        tgl, tmo, wl, rdl, er_all;
  logic [20:0] la, pa;
  logic [7:0]  ld, pd, last_q, st, rd;
  int          cnt;
  wire         drv = !flash_ce_n && !flash_oe_n;
  initial begin
    foreach (mem[k]) mem[k] = 8'hFF;
    {seq, mode, tgl, tmo, wl, rdl, last_q, cnt} = '0;
  end
  assign st = {(mode == 3'h1 || mode == 3'h4) ? ~pd[7] : 1'h0, tgl, tmo, 1'h0, mode == 3'h3, 3'h0};
  always_comb rd = (mode != 3'h0) ? st : mem[flash_addr];
  // A released bus shows the inverse of the last byte, so a stale value cannot pass.
  assign flash_dq_i = flash_dq_oe ? flash_dq_o : drv ? rd : ~last_q;
  task automatic erase();
    foreach (mem[k]) if (er_all || k[20:16] == er_sec) mem[k] = 8'hFF;
  endtask : erase
  task automatic cmd(input logic [20:0] a, input logic [7:0] d);
    if (d == CMD_RESET && (mode == 3'h0 || mode == 3'h4)) begin
      mode <= 3'h0;
      tmo <= 1'h0;
      seq <= 3'h0;
    end else if (mode == 3'h0) begin
      seq <= 3'h0;
      if (seq inside {3'h0, 3'h4} && a == UNLOCK1_ADDR && d == UNLOCK1_DATA) seq <= seq + 3'h1;
      if (seq inside {3'h1, 3'h5} && a == UNLOCK2_ADDR && d == UNLOCK2_DATA) seq <= seq + 3'h1;
      if (seq == 3'h2 && a == UNLOCK1_ADDR && d == CMD_PROG) seq <= 3'h3;
      if (seq == 3'h2 && a == UNLOCK1_ADDR && d == CMD_ERASE) seq <= 3'h4;
      if (seq == 3'h3) begin
        pa <= a;
        pd <= d;
        mode <= ((mem[a] & d) == d) ? 3'h1 : 3'h4;
        cnt <= ((mem[a] & d) != d) ? LOCK_CYC : stretch ? SLOW_CYC : PROG_CYC;
      end
      if (seq == 3'h6 && (d == CMD_SECT || (d == CMD_CHIP && a == UNLOCK1_ADDR))) begin
        er_all <= d == CMD_CHIP;
        er_sec <= a[20:16];
        mode <= (d == CMD_CHIP) ? 3'h3 : 3'h2;
        cnt <= (d == CMD_CHIP) ? ERASE_CYC : WIN_CYC;
      end
    end
  endtask : cmd
  always @(posedge pclk) begin
    rdl <= drv;
    if (drv) last_q <= rd;
    if (rdl && !drv && mode != 3'h0) tgl <= ~tgl;
    if (mode != 3'h0 && cnt != 0) cnt <= cnt - 1;
    else if (mode == 3'h1) begin
      mem[pa] <= pd;
      mode <= 3'h0;
    end else if (mode == 3'h2) begin
      mode <= 3'h3;
      cnt <= ERASE_CYC;
    end else if (mode == 3'h3) begin
      erase();
      mode <= 3'h0;
    end else if (mode == 3'h4) tmo <= 1'h1;
    wl <= !flash_we_n && !flash_ce_n;
    if (!flash_we_n && !flash_ce_n) begin
      la <= flash_addr;
      ld <= flash_dq_o;
    end else if (wl) cmd(la, ld);
  end
endmodule : fepe_flash_model

// ---- verif/test_flash_embedded_program_erase.sv ----
`timescale 1ns/100ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); end end
module test_flash_embedded_program_erase;
  import fepe_pkg::*;
  localparam int LIMIT = 20000;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err_q, stretch;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, st;
  logic [20:0] fa;
  logic [7:0]  fdo, fdi, b;
  logic        foe, fce, fre, fwe;
  int          n_mismatch, checked, cyc, n;
  fepe_host #(.PROG_WAIT_CYC(200), .SECT_WAIT_CYC(200), .CHIP_WAIT_CYC(200)) i_fepe_host (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_addr(fa), .flash_dq_o(fdo), .flash_dq_oe(foe),
    .flash_dq_i(fdi), .flash_ce_n(fce), .flash_oe_n(fre), .flash_we_n(fwe));
  fepe_flash_model i_fepe_flash_model (
    .pclk(pclk), .flash_addr(fa), .flash_dq_o(fdo), .flash_dq_oe(foe), .flash_dq_i(fdi),
    .flash_ce_n(fce), .flash_oe_n(fre), .flash_we_n(fwe), .stretch(stretch));
  always #10 pclk = ~pclk;
  task automatic results();
    $display("Compared %0d, mismatched %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      results();
    end
  end
  // Entered just after a rising edge; returns one edge after release.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err_q = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic run_op(input logic [2:0] op, input logic [20:0] a, input logic [7:0] d,
                        output logic [31:0] s);
    logic [31:0] x;
    int          k;
    apb(ADDR_OFS, 1'h1, 32'(a), x);
    apb(WDATA_OFS, 1'h1, 32'(d), x);
    apb(CTRL_OFS, 1'h1, 32'(op), x);
    k = 0;
    do begin
      apb(STATUS_OFS, 1'h0, 32'h0, s);
      k++;
    end while (s[STS_BUSY] !== 1'h0 && k < 2000);
  endtask : run_op
  task automatic rd_byte(input logic [20:0] a, output logic [7:0] v);
    logic [31:0] s, x;
    run_op(OP_READ, a, 8'h00, s);
    apb(RDATA_OFS, 1'h0, 32'h0, x);
    v = x[7:0];
  endtask : rd_byte
  initial begin
    {pclk, presetn, psel, penable, pwrite, stretch, paddr, pwdata} = '0;
    {n_mismatch, checked, cyc} = '0;
    clk_en = 1'h1;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(STATUS_OFS, 1'h0, 32'h0, r);
    `CHK(r, 32'h0)
    apb(12'h014, 1'h0, 32'h0, r);
    `CHK({err_q, r}, 33'h100000000)
    rd_byte(21'h012345, b);
    `CHK(b, 8'hFF)
    // A low clock enable must hold a running read with its strobes asserted.
    apb(ADDR_OFS, 1'h1, 32'h00012345, r);
    apb(CTRL_OFS, 1'h1, 32'(OP_READ), r);
    clk_en <= 1'h0;
    repeat (20) @(posedge pclk);
    `CHK({fce, fre}, 2'h0)
    clk_en <= 1'h1;
    @(posedge pclk);
    rd_byte(21'h012345, b);
    `CHK(b, 8'hFF)
    $display("Test reset finished");
    run_op(OP_PROG, 21'h012345, 8'h5A, st);
    `CHK(st[2:0], 3'h2)
    rd_byte(21'h012345, b);
    `CHK(b, 8'h5A)
    `CHK(i_fepe_flash_model.mem[21'h012346], 8'hFF)
    run_op(OP_PROG, 21'h030000, 8'h11, st);
    $display("Test program finished");
    run_op(OP_SECT, 21'h012345, 8'h00, st);
    `CHK(st[2:0], 3'h2)
    rd_byte(21'h012345, b);
    `CHK(b, 8'hFF)
    rd_byte(21'h030000, b);
    `CHK(b, 8'h11)
    $display("Test sector erase finished");
    run_op(OP_CHIP, 21'h000000, 8'h00, st);
    `CHK(st[2:0], 3'h2)
    rd_byte(21'h030000, b);
    `CHK(b, 8'hFF)
    $display("Test chip erase finished");
    run_op(OP_PROG, 21'h000100, 8'h00, st);
    run_op(OP_PROG, 21'h000100, 8'h0F, st);
    `CHK({st[STS_TMO], st[STS_HTMO], st[STS_FAIL]}, 3'h5)
    rd_byte(21'h000100, b);
    `CHK(b, 8'h00)
    $display("Test lockout finished");
    stretch <= 1'h1;
    run_op(OP_PROG, 21'h000200, 8'h33, st);
    stretch <= 1'h0;
    `CHK({st[STS_HTMO], st[STS_FAIL]}, 2'h3)
    n = 0;
    while (i_fepe_flash_model.mode !== 3'h0 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    rd_byte(21'h000200, b);
    `CHK(b, 8'h33)
    run_op(OP_RESET, 21'h000000, 8'h00, st);
    apb(CTRL_OFS, 1'h0, 32'h0, r);
    `CHK(r[2:0], OP_RESET)
    $display("Test host wait finished");
    results();
  end
endmodule : test_flash_embedded_program_erase
